/* File: common/dbc_if.sv */
// interface: command pins between controller and memory device
`timescale 1ns/1ps
interface dbc_if;
  logic                     cke;
  logic                     cs_n;
  logic                     ras_n;
  logic                     cas_n;
  logic                     we_n;
  logic                     odt;
  logic [dbc_pkg::BA_W-1:0] ba;
  logic [dbc_pkg::ADDR_W-1:0] addr;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n,
                output odt, output ba, output addr);
  modport dev  (input cke, input cs_n, input ras_n, input cas_n, input we_n,
                input odt, input ba, input addr);
endinterface // dbc_if

/* File: common/dbc_pkg.sv */
// package: command encodings, bank states and timing counts for the bank command block
// Notes on behaviour
// - mode register three written only by load
// - controller issues load without checking that all banks are idle
// - reserved mode bits driven as zero
// - decode from select, strobes, enable at edge
// - bank address picks the loaded register
// - bank commands go to addressed bank
// - a10 means auto precharge or all banks
// - four-beat reads run to completion before precharge; the device restarts a burst on a new column command and cuts a write at precharge
// - no refresh during power down
// - termination input ignored by decode
// - self refresh exit is synchronous; the device leaves it on a pclk edge once the synchronised enable reads high
// - don't-care inputs driven to defined levels
// - acceptance needs enable high twice, exit delay
// - idle after precharge period and read end
// - idle accepts activate, refresh, load
// - row active accepts read, write, precharge
// - read burst accepts read, write, precharge
// - write burst accepts read, write, precharge
// - precharging blocks bank until period ends
// - activating blocks bank until column delay
// - auto precharge keeps bank busy until done
// - refreshing blocks refresh and load until done; activate is still accepted
// - load occupies device until set delay
// - refresh and load only when all idle
package dbc_pkg;
  localparam int CLK_MHZ      = 40;
  localparam int NBANK        = 4;
  localparam int BA_W         = 2;
  localparam int ADDR_W       = 13;
  localparam int A10_POS      = 10;
  localparam int BURST_LEN    = 4;
  localparam int BURST_CYC    = BURST_LEN / 2;
  localparam int T_RP_NS      = 15;
  localparam int T_RCD_NS     = 15;
  localparam int T_RFC_NS     = 75;
  localparam int T_MRD_CK     = 2;
  localparam int T_XSNR_NS    = 200;
  localparam int T_WR_NS      = 15;
  localparam int CNT_W        = 8;
  // least times round up to whole cycles, never under one
  localparam int RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int RCD_CYC  = (T_RCD_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int RFC_CYC  = (T_RFC_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int XSNR_CYC = (T_XSNR_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_XSNR_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_CYC   = (T_WR_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (T_WR_NS * CLK_MHZ + 999) / 1000;
  // mode register selects on the bank address lines
  localparam logic [1:0] MR_SEL_MODE = 2'h0;
  localparam logic [1:0] MR_SEL_EXT1 = 2'h1;
  localparam logic [1:0] MR_SEL_EXT2 = 2'h2;
  localparam logic [1:0] MR_SEL_EXT3 = 2'h3;
  // decoded commands; {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DBC_CMD_LOAD = 4'h0, DBC_CMD_REF = 4'h1, DBC_CMD_PRE = 4'h2, DBC_CMD_ACT = 4'h3,
    DBC_CMD_WR   = 4'h4, DBC_CMD_RD  = 4'h5, DBC_CMD_NOP = 4'h7, DBC_CMD_DES = 4'h8
  } dbc_cmd_e;
  typedef enum logic [2:0] {
    DBC_BK_IDLE, DBC_BK_ACTIVATING, DBC_BK_ACTIVE, DBC_BK_READ, DBC_BK_WRITE,
    DBC_BK_AUTO_PRE, DBC_BK_PRECHARGING
  } dbc_bank_e;
  // controller order codes on the apb side
  localparam logic [2:0] ORD_NOP  = 3'h0;
  localparam logic [2:0] ORD_ACT  = 3'h1;
  localparam logic [2:0] ORD_RD   = 3'h2;
  localparam logic [2:0] ORD_WR   = 3'h3;
  localparam logic [2:0] ORD_PRE  = 3'h4;
  localparam logic [2:0] ORD_REF  = 3'h5;
  localparam logic [2:0] ORD_LOAD = 3'h6;
  localparam logic [2:0] ORD_SELF = 3'h7;
  // controller register offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PDOWN  = 8'h0C;
  // command register fields
  localparam int CMD_ORD_LSB = 0;
  localparam int CMD_BA_LSB  = 4;
  localparam int CMD_GO_BIT  = 8;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

/* File: hdl/dbc_ctrl.sv */
// controller end: apb registers turned into command pin sequences
`timescale 1ns/1ps
module dbc_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  dbc_if.ctrl              pins
);
  import dbc_pkg::*;

  logic [2:0]        ord_q;
  logic [BA_W-1:0]   ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic              busy_q, pdown_q;
  logic [CNT_W-1:0]  wait_q;
  logic              acc;
  assign acc = psel && penable;

  // apb slave: zero wait states, unmapped offsets answer with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= REG_RESET;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(paddr == OFS_CMD || paddr == OFS_ADDR || paddr == OFS_STATUS ||
                   paddr == OFS_PDOWN);
      prdata  <= REG_RESET;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CMD:    prdata <= {23'h0, busy_q, 2'h0, ba_q, 1'b0, ord_q};
          OFS_ADDR:   prdata <= {19'h0, addr_q};
          OFS_STATUS: prdata <= {30'h0, pdown_q, busy_q};
          OFS_PDOWN:  prdata <= {31'h0, pdown_q};
          default:    prdata <= REG_RESET;
        endcase
      end
    end
  end

  // one order at a time; a command write while busy is dropped
  logic go;
  assign go = acc && pready && pwrite && paddr == OFS_CMD && pwdata[CMD_GO_BIT] && !busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ord_q   <= ORD_NOP;
      ba_q    <= '0;
      addr_q  <= '0;
      pdown_q <= 1'b0;
    end else begin
      if (acc && pready && pwrite && paddr == OFS_ADDR) addr_q <= pwdata[ADDR_W-1:0];
      if (acc && pready && pwrite && paddr == OFS_PDOWN) pdown_q <= pwdata[0];
      if (go) begin
        ord_q <= pwdata[CMD_ORD_LSB +: 3];
        ba_q  <= pwdata[CMD_BA_LSB +: BA_W];
      end
    end
  end

  // pins: one command cycle then nop for one fixed hold time, the same for every order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.cke   <= 1'b1;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hF;
      pins.odt   <= 1'b0;
      pins.ba    <= '0;
      pins.addr  <= '0;
      busy_q     <= 1'b0;
      wait_q     <= '0;
    end else begin
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_NOP;
      pins.cke <= !pdown_q;
      if (go) begin
        busy_q    <= 1'b1;
        pins.ba   <= pwdata[CMD_BA_LSB +: BA_W];
        pins.addr <= addr_q;
        wait_q    <= CNT_W'(RFC_CYC + XSNR_CYC / 4 + 4); // covers longest hold
        case (pwdata[CMD_ORD_LSB +: 3])
          ORD_ACT:  {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_ACT;
          ORD_RD:   {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_RD;
          ORD_WR:   {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_WR;
          ORD_PRE:  {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_PRE;
          ORD_REF:  {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_REF;
          ORD_LOAD: begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_LOAD;
            if (pwdata[CMD_BA_LSB +: BA_W] == MR_SEL_EXT3) pins.addr <= '0;
          end
          default:  {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= DBC_CMD_NOP;
        endcase
      end else if (busy_q) begin
        if (wait_q == '0) busy_q <= 1'b0;
        else wait_q <= wait_q - 1'b1;
      end
    end
  end
endmodule // dbc_ctrl

/* File: hdl/dbc_device.sv */
// device end: command decode, per-bank state tracking, mode register three
`timescale 1ns/1ps
module dbc_device (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  dbc_if.dev                                pins,
  output logic [dbc_pkg::ADDR_W-1:0]        ext_mode_three,
  output logic [dbc_pkg::NBANK*3-1:0]       bank_state,
  output logic                              self_refresh,
  output logic                              odt_active,
  output logic                              cmd_error
);
  import dbc_pkg::*;

  // pins come from another chip: two flip-flops before use
  logic cke_s1_q, cke_q, cs_s1_q, cs_q, ras_s1_q, ras_q, cas_s1_q, cas_q, we_s1_q, we_q;
  logic odt_s1_q, odt_q;
  logic [BA_W-1:0]   ba_s1_q, ba_q;
  logic [ADDR_W-1:0] ad_s1_q, ad_q;
  logic              cke_prev_q;
  logic [ADDR_W-1:0] extended_mode_register_three_q;
  dbc_bank_e         bk_q [NBANK];
  logic [CNT_W-1:0]  bcnt_q [NBANK];
  logic [CNT_W-1:0]  dev_cnt_q;
  logic              sr_q, err_q;
  logic [CNT_W-1:0]  xsnr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cke_s1_q, cke_q, odt_s1_q, odt_q} <= 4'h0;
      {cs_s1_q, cs_q, ras_s1_q, ras_q, cas_s1_q, cas_q, we_s1_q, we_q} <= 8'hFF;
      ba_s1_q <= '0;
      ba_q    <= '0;
      ad_s1_q <= '0;
      ad_q    <= '0;
      cke_prev_q <= 1'b0;
    end else begin
      cke_s1_q <= pins.cke;  cke_q <= cke_s1_q;
      cs_s1_q  <= pins.cs_n; cs_q  <= cs_s1_q;
      ras_s1_q <= pins.ras_n; ras_q <= ras_s1_q;
      cas_s1_q <= pins.cas_n; cas_q <= cas_s1_q;
      we_s1_q  <= pins.we_n; we_q  <= we_s1_q;
      odt_s1_q <= pins.odt;  odt_q <= odt_s1_q;
      ba_s1_q  <= pins.ba;   ba_q  <= ba_s1_q;
      ad_s1_q  <= pins.addr; ad_q  <= ad_s1_q;
      cke_prev_q <= cke_q;
    end
  end

  // decode ignores termination input entirely
  dbc_cmd_e cmd;
  logic     ck_ok, all_idle, ap;
  always_comb begin
    cmd = cs_q ? DBC_CMD_DES : dbc_cmd_e'({1'b0, ras_q, cas_q, we_q});
    ck_ok = cke_prev_q && cke_q && !sr_q && (xsnr_q == '0);
    ap = ad_q[A10_POS];
    all_idle = (dev_cnt_q == '0);
    for (int i = 0; i < NBANK; i++) begin
      if (bk_q[i] != DBC_BK_IDLE) all_idle = 1'b0;
    end
  end

  // self refresh: entry on edge, exit as soon as enable returns, no command needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q   <= 1'b0;
      xsnr_q <= '0;
    end else if (sr_q && cke_q) begin
      sr_q   <= 1'b0;
      xsnr_q <= CNT_W'(XSNR_CYC);
    end else if (cke_prev_q && !cke_q && cmd == DBC_CMD_REF && all_idle) begin
      sr_q <= 1'b1;
    end else if (xsnr_q != '0) begin
      xsnr_q <= xsnr_q - 1'b1;
    end
  end

  // device-wide busy: refresh and load block further refresh and load; banks still accept activate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_cnt_q <= '0;
    end else if (ck_ok && all_idle && cmd == DBC_CMD_REF) begin
      dev_cnt_q <= CNT_W'(RFC_CYC);
    end else if (ck_ok && all_idle && cmd == DBC_CMD_LOAD) begin
      dev_cnt_q <= CNT_W'(T_MRD_CK);
    end else if (dev_cnt_q != '0) begin
      dev_cnt_q <= dev_cnt_q - 1'b1;
    end
  end

  // only a load with the third selector writes it; kept until the next load with that selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_mode_register_three_q <= '0;
    end else if (ck_ok && all_idle && cmd == DBC_CMD_LOAD && ba_q == MR_SEL_EXT3) begin
      extended_mode_register_three_q <= ad_q;
    end
  end

  // per-bank state; commands the state does not accept flag an error
  logic [NBANK-1:0] bad;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NBANK; i++) begin
        bk_q[i]   <= DBC_BK_IDLE;
        bcnt_q[i] <= '0;
      end
      bad <= '0;
    end else begin
      for (int i = 0; i < NBANK; i++) begin
        logic hit, pre_hit;
        hit     = ck_ok && (ba_q == BA_W'(i));
        pre_hit = ck_ok && cmd == DBC_CMD_PRE && (ap || ba_q == BA_W'(i));
        bad[i]  <= 1'b0;
        if (bcnt_q[i] != '0) bcnt_q[i] <= bcnt_q[i] - 1'b1;
        case (bk_q[i])
          DBC_BK_IDLE: begin
            if (hit && cmd == DBC_CMD_ACT) begin
              bk_q[i] <= DBC_BK_ACTIVATING;
              bcnt_q[i] <= CNT_W'(RCD_CYC);
            end else if (hit && (cmd == DBC_CMD_RD || cmd == DBC_CMD_WR)) bad[i] <= 1'b1;
          end
          DBC_BK_ACTIVATING, DBC_BK_PRECHARGING, DBC_BK_AUTO_PRE: begin
            if (hit && cmd != DBC_CMD_DES && cmd != DBC_CMD_NOP &&
                cmd != DBC_CMD_REF && cmd != DBC_CMD_LOAD) bad[i] <= 1'b1;
            if (bcnt_q[i] <= CNT_W'(1)) begin
              bk_q[i] <= (bk_q[i] == DBC_BK_ACTIVATING) ? DBC_BK_ACTIVE : DBC_BK_IDLE;
            end
          end
          DBC_BK_ACTIVE, DBC_BK_READ, DBC_BK_WRITE: begin
            // bursts of four run out; a new column command starts another
            if (bk_q[i] != DBC_BK_ACTIVE && bcnt_q[i] <= CNT_W'(1)) bk_q[i] <= DBC_BK_ACTIVE;
            if (pre_hit) begin
              bk_q[i] <= DBC_BK_PRECHARGING;
              bcnt_q[i] <= CNT_W'(RP_CYC + (bk_q[i] == DBC_BK_READ ? BURST_CYC : 0));
            end else if (hit && (cmd == DBC_CMD_RD || cmd == DBC_CMD_WR)) begin
              if (ap) begin
                bk_q[i] <= DBC_BK_AUTO_PRE;
                bcnt_q[i] <= CNT_W'(BURST_CYC + RP_CYC + (cmd == DBC_CMD_WR ? WR_CYC : 0));
              end else begin
                bk_q[i] <= (cmd == DBC_CMD_RD) ? DBC_BK_READ : DBC_BK_WRITE;
                bcnt_q[i] <= CNT_W'(BURST_CYC);
              end
            end else if (hit && cmd == DBC_CMD_ACT) bad[i] <= 1'b1;
          end
          default: bk_q[i] <= DBC_BK_IDLE;
        endcase
      end
    end
  end

  // outputs all registered; no refresh is counted in power down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode_three <= '0;
      bank_state     <= '0;
      self_refresh   <= 1'b0;
      odt_active     <= 1'b0;
      cmd_error      <= 1'b0;
      err_q          <= 1'b0;
    end else begin
      ext_mode_three <= extended_mode_register_three_q;
      for (int i = 0; i < NBANK; i++) bank_state[i*3 +: 3] <= bk_q[i];
      self_refresh <= sr_q;
      odt_active   <= odt_q && !sr_q;
      err_q        <= ck_ok && (cmd == DBC_CMD_REF || cmd == DBC_CMD_LOAD) && !all_idle;
      cmd_error    <= (|bad) || err_q;
    end
  end
endmodule // dbc_device

/* File: test/dbc_monitor.sv */
// checker: command pin rules watched on the interface between the two ends
`timescale 1ns/1ps
module dbc_monitor
  import dbc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic              odt,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr
);
  logic       cmd_any, is_ref, is_load, is_act, is_pre, is_col;
  logic [3:0] open_q;
  // command decode from the strobes; deselect and nop count as no command
  assign cmd_any = !cs_n && !(ras_n && cas_n && we_n);
  assign is_ref  = !cs_n && !ras_n && !cas_n && we_n;
  assign is_load = !cs_n && !ras_n && !cas_n && !we_n;
  assign is_act  = !cs_n && !ras_n && cas_n && we_n;
  assign is_pre  = !cs_n && !ras_n && cas_n && !we_n;
  assign is_col  = !cs_n && ras_n && !cas_n;
  // banks left open by the pins; kept here since the checker sees no device state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 4'h0;
    end else if (cke && is_act) begin
      open_q[ba] <= 1'b1;
    end else if (cke && is_pre && addr[A10_POS]) begin
      open_q <= 4'h0;
    end else if (cke && (is_pre || (is_col && addr[A10_POS]))) begin
      open_q[ba] <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet2;
    !cmd_any ##1 !cmd_any;
  endsequence
  a_cmd_then_nop: assert property (cmd_any |=> !cmd_any)
    else $error("command held longer than one cycle");
  a_cke_twice_high: assert property (cmd_any |-> cke && $past(cke))
    else $error("command issued without clock enable high twice");
  a_extended_mode_register_three_reserved_zero: assert property (is_load && ba == MR_SEL_EXT3 |-> addr == '0)
    else $error("reserved mode bits not zero");
  a_load_all_idle: assert property ((is_load || is_ref) |-> open_q == 4'h0)
    else $error("load or refresh with a bank open");
  a_load_settle: assert property (is_load |=> s_quiet2)
    else $error("command inside the mode set delay");
  a_refresh_quiet: assert property (is_ref |=> !cmd_any [*3])
    else $error("command inside the refresh cycle");
  a_burst_whole: assert property (is_col |=> s_quiet2)
    else $error("burst interrupted");
  a_pdown_no_refresh: assert property (!cke |-> !is_ref)
    else $error("refresh during power down");
  a_act_only_idle: assert property (is_act |-> !open_q[ba])
    else $error("activate to an open bank");
endmodule // dbc_monitor

/* File: test/test_dram_bank_command_state.sv */
// testbench: apb orders through the controller, device bank states judged
`timescale 1ns/1ps
module test_dram_bank_command_state;
  import dbc_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready, pslverr, self_refresh, odt_active, cmd_error;
  logic [ADDR_W-1:0]  ext_mode_three;
  logic [NBANK*3-1:0] bank_state;
  logic               err_seen = 1'b0;
  int                 n_errors = 0;
  int                 n_tests = 0;
  dbc_if u_dbc_if ();
  dbc_ctrl u_dbc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(u_dbc_if.ctrl));
  dbc_device u_dbc_device (.pclk(pclk), .presetn(presetn), .pins(u_dbc_if.dev),
    .ext_mode_three(ext_mode_three), .bank_state(bank_state), .self_refresh(self_refresh),
    .odt_active(odt_active), .cmd_error(cmd_error));
  dbc_monitor u_dbc_monitor (.pclk(pclk), .presetn(presetn), .cke(u_dbc_if.cke),
    .cs_n(u_dbc_if.cs_n), .ras_n(u_dbc_if.ras_n), .cas_n(u_dbc_if.cas_n),
    .we_n(u_dbc_if.we_n), .odt(u_dbc_if.odt), .ba(u_dbc_if.ba), .addr(u_dbc_if.addr));
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // the illegal-command flag pulses for one cycle only, so it is latched
  always @(posedge pclk) if (cmd_error === 1'b1) err_seen <= 1'b1;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic go(input logic [2:0] o, input logic [1:0] b);
    logic [31:0] q; logic e;
    apb(1'b1, OFS_CMD, {23'h0, 1'b1, 2'h0, b, 1'b0, o}, q, e);
  endtask
  // busy covers the device's own settling, so polling it bounds every wait
  task automatic wait_idle;
    logic [31:0] q; logic e; int n;
    n = 0;
    do begin apb(1'b0, OFS_STATUS, 32'h0, q, e); n++; end while (q[0] !== 1'b0 && n < 40);
  endtask
  task automatic order(input logic [2:0] o, input logic [1:0] b, input logic [12:0] a);
    logic [31:0] q; logic e;
    apb(1'b1, OFS_ADDR, {19'h0, a}, q, e);
    go(o, b);
    wait_idle;
  endtask
  task automatic bank_is(input int b, input dbc_bank_e s);
    check(32'(bank_state[b*3+:3]), 32'(s), "bank state");
  endtask
  task automatic t_regs;
    logic [31:0] q; logic e;
    apb(1'b0, 8'h10, 32'h0, q, e);
    check(32'(e), 32'h1, "unmapped offset error");
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    check(q & 32'h3, 32'h0, "status after reset");
    $display("test regs done");
  endtask
  task automatic t_banks;
    for (int b = 0; b < NBANK; b++) begin
      order(ORD_ACT, 2'(b), 13'h0123);
      bank_is(b, DBC_BK_ACTIVE);
    end
    order(ORD_RD, 2'h1, 13'h0008);
    bank_is(1, DBC_BK_ACTIVE);
    order(ORD_WR, 2'h1, 13'h0010);
    bank_is(1, DBC_BK_ACTIVE);
    order(ORD_RD, 2'h1, 13'h0400);
    bank_is(1, DBC_BK_IDLE);
    order(ORD_WR, 2'h0, 13'h0400);
    bank_is(0, DBC_BK_IDLE);
    order(ORD_PRE, 2'h2, 13'h0000);
    bank_is(2, DBC_BK_IDLE);
    bank_is(3, DBC_BK_ACTIVE);
    order(ORD_PRE, 2'h0, 13'h0400);
    bank_is(3, DBC_BK_IDLE);
    $display("test banks done");
  endtask
  task automatic t_refused;
    logic [31:0] q; logic e;
    apb(1'b1, OFS_ADDR, 32'h0000_0055, q, e);
    go(ORD_ACT, 2'h2);
    go(ORD_PRE, 2'h2);
    wait_idle;
    bank_is(2, DBC_BK_ACTIVE);
    order(ORD_PRE, 2'h1, 13'h0400);
    bank_is(2, DBC_BK_IDLE);
    $display("test refused done");
  endtask
  task automatic t_ref_load;
    order(ORD_REF, 2'h0, 13'h0000);
    for (int b = 0; b < NBANK; b++) bank_is(b, DBC_BK_IDLE);
    order(ORD_LOAD, MR_SEL_EXT3, 13'h1FFF);
    check(32'(ext_mode_three), 32'h0, "mode register three");
    order(ORD_LOAD, MR_SEL_EXT1, 13'h0ABC);
    check(32'(ext_mode_three), 32'h0, "mode register three kept");
    for (int b = 0; b < NBANK; b++) bank_is(b, DBC_BK_IDLE);
    $display("test refresh load done");
  endtask
  task automatic t_pdown;
    logic [31:0] q; logic e;
    apb(1'b1, OFS_PDOWN, 32'h1, q, e);
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    check(32'(q[1]), 32'h1, "power down status");
    check(32'(u_dbc_if.cke), 32'h0, "clock enable low");
    check(32'(self_refresh), 32'h0, "no self refresh");
    check(32'(odt_active), 32'h0, "termination off");
    apb(1'b1, OFS_PDOWN, 32'h0, q, e);
    wait_idle;
    check(32'(u_dbc_if.cke), 32'h1, "clock enable high");
    order(ORD_ACT, 2'h0, 13'h0001);
    bank_is(0, DBC_BK_ACTIVE);
    order(ORD_PRE, 2'h0, 13'h0000);
    bank_is(0, DBC_BK_IDLE);
    $display("test power down done");
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_banks;
    t_refused;
    t_ref_load;
    t_pdown;
    check(32'(err_seen), 32'h0, "illegal command flagged");
    complete_run;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule // test_dram_bank_command_state
